// file: include/color_mode_pkg.sv
package color_mode_pkg;

    // ------------------------------------------------------------
    // Host I/O map
    // ------------------------------------------------------------
    localparam logic [15:0] PIXEL_MASK_PORT   = 16'h03c6;
    localparam logic [7:0]  HIDDEN_RESET      = 8'h00;
    localparam logic [7:0]  PIXEL_MASK_RESET  = 8'hff;

    // ------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------
    localparam int          UNLOCK_READS      = 4;
    localparam int          CNT_W             = 3;

    // ------------------------------------------------------------
    // Hidden register fields
    // ------------------------------------------------------------
    localparam int          EXT_ENABLE_BIT    = 7;
    localparam int          SEL_ENABLE_BIT    = 6;
    localparam int          RSVD_HI_BIT       = 5;
    localparam int          RSVD_LO_BIT       = 4;
    localparam int          SEL_HI_BIT        = 3;
    localparam int          SEL_LO_BIT        = 0;

    localparam logic [3:0]  SEL_RGB565        = 4'h1;
    localparam logic [3:0]  SEL_RGB888        = 4'h5;
    localparam logic [2:0]  SEL_PWRDN_TOP     = 3'h3;
    localparam logic [3:0]  SEL_GRAY8         = 4'h8;

    typedef enum logic [2:0] {
        MODE_VGA      = 3'b000,
        MODE_RGB555   = 3'b001,
        MODE_RGB565   = 3'b010,
        MODE_RGB888   = 3'b011,
        MODE_PWRDN    = 3'b100,
        MODE_GRAY8    = 3'b101,
        MODE_RESERVED = 3'b110
    } color_mode_t;

endpackage

// file: hdl/color_mode_decode.sv
module color_mode_decode (
    input  wire logic [7:0]                 hidden_value,
    output color_mode_pkg::color_mode_t     mode
);
    import color_mode_pkg::*;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    wire       ext_en  = hidden_value[EXT_ENABLE_BIT];
    wire       sel_en  = hidden_value[SEL_ENABLE_BIT];
    wire [1:0] rsvd    = hidden_value[RSVD_HI_BIT:RSVD_LO_BIT];
    wire [3:0] sel     = hidden_value[SEL_HI_BIT:SEL_LO_BIT];

    // Reserved bits only matter once the selector is in use
    wire sel_ok = (rsvd == 2'b00);

    assign mode = !ext_en                                   ? MODE_VGA      :
                  !sel_en                                   ? MODE_RGB555   :
                  (sel_ok && sel == SEL_RGB565)             ? MODE_RGB565   :
                  (sel_ok && sel == SEL_RGB888)             ? MODE_RGB888   :
                  (sel_ok && sel[3:1] == SEL_PWRDN_TOP)     ? MODE_PWRDN    :
                  (sel_ok && sel == SEL_GRAY8)              ? MODE_GRAY8    :
                                                              MODE_RESERVED;

endmodule

// file: hdl/hidden_color_mode_register.sv
// Notes on behaviour
// - Four uninterrupted mask-port reads steer the next mask-port access to the hidden register.
// - Any hidden read or write clears the read counter; four reads needed again.
// - The next mask-port read or write after unlock is a hidden access and relocks; other cycles leave the hidden register reachable.
// - Reset clears the hidden register to zero, giving VGA-compatible palette.
// - Colour mode has no effect on video-window modes.
// - Top bit clear means VGA-compatible DAC; other bits ignored.
// - Top bit set, select-enable clear gives RGB 5-5-5; low nibble ignored.
// - Top and select-enable set: low nibble selects a non-5-5-5 extended mode.
// - Nibble 0001 is 5-6-5, 0101 is 8-8-8, 011x power-down, 1000 grayscale.
module hidden_color_mode_register #(
    parameter int                unlock_reads = color_mode_pkg::UNLOCK_READS
) (
    input  wire logic                       mclk,
    input  wire logic                       rst,
    input  wire logic [15:0]                io_addr,
    input  wire logic                       io_rd,
    input  wire logic                       io_wr,
    input  wire logic [7:0]                 io_wdata,
    output logic      [7:0]                 io_rdata,
    output logic                            io_rvalid,
    output logic      [7:0]                 pixel_mask,
    output logic      [7:0]                 hidden_color_mode_select,
    output logic                            hidden_armed,
    output color_mode_pkg::color_mode_t     color_mode
);
    import color_mode_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (unlock_reads < 1 || unlock_reads >= (1 << CNT_W))
    begin
        $error("unlock_reads out of range for counter width");
    end

    localparam logic [CNT_W-1:0] UNLOCK_CNT = CNT_W'(unlock_reads);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [7:0]       hidden_reg;
    logic [7:0]       hidden_next;
    logic [7:0]       mask_reg;
    logic [7:0]       mask_next;
    logic [7:0]       rdata_reg;
    logic [7:0]       rdata_next;
    logic             rvalid_reg;
    logic             armed_reg;
    color_mode_t      mode_reg;
    color_mode_t      mode_next;

    // Reads take priority if a host ever raises both strobes
    wire port_hit   = (io_addr == PIXEL_MASK_PORT);
    wire port_rd    = port_hit && io_rd;
    wire port_wr    = port_hit && io_wr && !io_rd;
    wire unlocked   = (cnt_reg == UNLOCK_CNT);
    wire hidden_acc = unlocked && (port_rd || port_wr);

    assign cnt_next = hidden_acc              ? '0 :
                      port_wr                 ? '0 :
                      (port_rd && !unlocked)  ? cnt_reg + 1'b1 :
                                                cnt_reg;

    assign hidden_next = (unlocked && port_wr) ? io_wdata : hidden_reg;
    assign mask_next   = (!unlocked && port_wr) ? io_wdata : mask_reg;
    assign rdata_next  = !port_rd ? rdata_reg :
                         unlocked ? hidden_reg : mask_reg;

    // ------------------------------------------------------------
    // Mode decode; video-window paths take nothing from here
    // ------------------------------------------------------------
    color_mode_decode u_decode (
        .hidden_value (hidden_reg),
        .mode         (mode_next)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt_reg    <= '0;
            hidden_reg <= HIDDEN_RESET;
            mask_reg   <= PIXEL_MASK_RESET;
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
            armed_reg  <= 1'b0;
            mode_reg   <= MODE_VGA;
        end
        else
        begin
            cnt_reg    <= cnt_next;
            hidden_reg <= hidden_next;
            mask_reg   <= mask_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= port_rd;
            armed_reg  <= (cnt_next == UNLOCK_CNT);
            mode_reg   <= mode_next;
        end
    end

    assign io_rdata                 = rdata_reg;
    assign io_rvalid                = rvalid_reg;
    assign pixel_mask               = mask_reg;
    assign hidden_color_mode_select = hidden_reg;
    assign hidden_armed             = armed_reg;
    assign color_mode               = mode_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_hidden_write;
        @(posedge mclk) disable iff (rst)
        (unlocked && port_wr) |=> (hidden_reg == $past(io_wdata)) && (cnt_reg == '0) && (mask_reg == $past(mask_reg));
    endproperty
    a_hidden_write: assert property (p_hidden_write) else $error("hidden write not taken");

    property p_hidden_read;
        @(posedge mclk) disable iff (rst)
        (unlocked && port_rd) |=> io_rvalid && (io_rdata == $past(hidden_reg)) && (cnt_reg == '0) && !hidden_armed;
    endproperty
    a_hidden_read: assert property (p_hidden_read) else $error("hidden read wrong or count kept");

    property p_plain_read;
        @(posedge mclk) disable iff (rst)
        (!unlocked && port_rd) |=> (io_rdata == $past(mask_reg)) && (cnt_reg == $past(cnt_reg) + 1'b1);
    endproperty
    a_plain_read: assert property (p_plain_read) else $error("mask read did not count");

    property p_stay_unlocked;
        @(posedge mclk) disable iff (rst)
        (unlocked && !port_rd && !port_wr) |=> unlocked && hidden_armed;
    endproperty
    a_stay_unlocked: assert property (p_stay_unlocked) else $error("unlock lost without access");

    property p_early_write;
        @(posedge mclk) disable iff (rst)
        (!unlocked && port_wr) |=> (cnt_reg == '0) && $stable(hidden_reg) && (mask_reg == $past(io_wdata));
    endproperty
    a_early_write: assert property (p_early_write) else $error("early write did not restart count");

    property p_reset_clear;
        @(posedge mclk)
        rst |-> (hidden_reg == HIDDEN_RESET) && (color_mode == MODE_VGA) && (cnt_reg == '0);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear hidden register");

    property p_vga;
        @(posedge mclk) disable iff (rst)
        !hidden_reg[EXT_ENABLE_BIT] ##1 !$past(hidden_reg[EXT_ENABLE_BIT]) |-> color_mode == MODE_VGA;
    endproperty
    a_vga: assert property (p_vga) else $error("VGA mode not selected");

    property p_rgb555;
        @(posedge mclk) disable iff (rst)
        (hidden_reg[EXT_ENABLE_BIT] && !hidden_reg[SEL_ENABLE_BIT]) |=> color_mode == MODE_RGB555;
    endproperty
    a_rgb555: assert property (p_rgb555) else $error("5-5-5 mode not selected");

    property p_rgb565;
        @(posedge mclk) disable iff (rst)
        (hidden_reg == 8'hc1) |=> color_mode == MODE_RGB565;
    endproperty
    a_rgb565: assert property (p_rgb565) else $error("5-6-5 mode not selected");

    property p_select_codes;
        @(posedge mclk) disable iff (rst)
        (hidden_reg[7:1] == 7'h63) |=> (color_mode == MODE_PWRDN) ##0
        ($past(hidden_reg[7:1]) == 7'h63);
    endproperty
    a_select_codes: assert property (p_select_codes) else $error("power-down code not decoded");

endmodule

// file: tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import color_mode_pkg::*;

    logic        mclk = 1'b0;
    logic        rst = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic        io_rd = 1'b0;
    logic        io_wr = 1'b0;
    logic [7:0]  io_wdata = 8'h00;
    logic [7:0]  io_rdata;
    logic        io_rvalid;
    logic [7:0]  pixel_mask;
    logic [7:0]  hidden_color_mode_select;
    logic        hidden_armed;
    color_mode_t color_mode;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cnt = 0;
    logic [7:0]  hid_exp = HIDDEN_RESET;
    logic [7:0]  mask_exp = PIXEL_MASK_RESET;
    logic [7:0]  codes [12] = '{8'h00, 8'h4f, 8'h80, 8'h8f, 8'h85, 8'hc1, 8'hc5, 8'hc6, 8'hc7, 8'hc8, 8'h81, 8'h88};

    always #25 mclk = ~mclk;

    hidden_color_mode_register #(.unlock_reads(UNLOCK_READS)) dut_u (
        .mclk                     (mclk),
        .rst                      (rst),
        .io_addr                  (io_addr),
        .io_rd                    (io_rd),
        .io_wr                    (io_wr),
        .io_wdata                 (io_wdata),
        .io_rdata                 (io_rdata),
        .io_rvalid                (io_rvalid),
        .pixel_mask               (pixel_mask),
        .hidden_color_mode_select (hidden_color_mode_select),
        .hidden_armed             (hidden_armed),
        .color_mode               (color_mode)
    );

    // ------------------------------------------------------------
    // Checking and reference model
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    function automatic color_mode_t mode_of(input logic [7:0] h);
        if (!h[7])
            return MODE_VGA;
        if (!h[6])
            return MODE_RGB555;
        if (h[5:4] != 2'b00)
            return MODE_RESERVED;
        if (h[3:0] == SEL_RGB565)
            return MODE_RGB565;
        if (h[3:0] == SEL_RGB888)
            return MODE_RGB888;
        if (h[3:1] == SEL_PWRDN_TOP)
            return MODE_PWRDN;
        if (h[3:0] == SEL_GRAY8)
            return MODE_GRAY8;
        return MODE_RESERVED;
    endfunction

    // ------------------------------------------------------------
    // Host accesses: kind 0 read, 1 write, 2 both strobes (a read)
    // ------------------------------------------------------------
    task automatic op(input int kind, input logic [15:0] addr, input logic [7:0] d);
        logic       hit;
        logic [7:0] rexp;
        hit = (addr === PIXEL_MASK_PORT);
        io_addr = addr;
        io_wdata = d;
        io_rd = (kind != 1);
        io_wr = (kind != 0);
        rexp = (cnt == UNLOCK_READS) ? hid_exp : mask_exp;
        @(posedge mclk);
        #5;
        if (hit && kind != 1)
        begin
            cnt = (cnt == UNLOCK_READS) ? 0 : cnt + 1;
            chk(io_rdata, rexp, "read data");
        end
        else if (hit)
        begin
            if (cnt == UNLOCK_READS)
                hid_exp = d;
            else
                mask_exp = d;
            cnt = 0;
        end
        chk({7'h0, io_rvalid}, {7'h0, hit && kind != 1}, "read valid");
        chk({7'h0, hidden_armed}, {7'h0, cnt == UNLOCK_READS}, "armed");
        chk(hidden_color_mode_select, hid_exp, "hidden");
        chk(pixel_mask, mask_exp, "mask");
    endtask

    // Decoded mode lags the register by one more cycle
    task automatic settle();
        io_rd = 1'b0;
        io_wr = 1'b0;
        repeat (2) @(posedge mclk);
        #5;
        chk({5'h0, color_mode}, {5'h0, mode_of(hid_exp)}, "mode");
    endtask

    initial
    begin
        #1000000;
        mismatches++;
        test_done();
    end

    initial
    begin
        void'($urandom(32'hce7a4506));
        // Raised after time zero so the asynchronous reset sees an edge before the first clock
        #1 rst = 1'b1;
        repeat (10) @(posedge mclk);
        #5 rst = 1'b0;
        settle();
        chk(hidden_color_mode_select, 8'h00, "reset hidden");
        foreach (codes[i])
        begin
            repeat (UNLOCK_READS) op(0, PIXEL_MASK_PORT, 8'h00);
            op(1, PIXEL_MASK_PORT, codes[i]);
            settle();
            repeat (UNLOCK_READS + 1) op(0, PIXEL_MASK_PORT, 8'h00);
        end
        // Mid-run reset while armed and holding a non-zero mode
        repeat (UNLOCK_READS) op(0, PIXEL_MASK_PORT, 8'h00);
        io_rd = 1'b0;
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        #5 rst = 1'b0;
        cnt = 0;
        hid_exp = HIDDEN_RESET;
        mask_exp = PIXEL_MASK_RESET;
        settle();
        chk(hidden_color_mode_select, HIDDEN_RESET, "reset hidden");
        chk({7'h0, hidden_armed}, 8'h00, "reset armed");
        chk(io_rdata, 8'h00, "reset read data");
        // Interrupted unlock, then an idle gap before the combined strobe access
        repeat (UNLOCK_READS - 1) op(0, PIXEL_MASK_PORT, 8'h00);
        op(1, PIXEL_MASK_PORT, 8'h5a);
        repeat (UNLOCK_READS) op(0, PIXEL_MASK_PORT, 8'h00);
        op(0, 16'h03c7, 8'h00);
        settle();
        op(2, PIXEL_MASK_PORT, 8'h33);
        repeat (600)
        begin
            op(($urandom_range(0, 7) > 5) ? $urandom_range(1, 2) : 0,
               ($urandom_range(0, 5) == 0) ? 16'($urandom) : PIXEL_MASK_PORT,
               (cnt == UNLOCK_READS) ? codes[$urandom_range(0, 11)] : 8'($urandom));
            if ($urandom_range(0, 3) == 0)
                settle();
        end
        test_done();
    end
endmodule
